/* File: shared/dom_pkg.sv */
// Shared constants for the driver output and mode control block.
package dom_pkg;
	// Serial command word layout.
	localparam int          CMD_W         = 16;
	localparam int          CMD_CODE_HI   = 15;
	localparam int          CMD_CODE_LO   = 12;
	localparam int          BYTE_BITS     = 8;
	localparam logic [3:0]  CMD_OUTPUT    = 4'h1;
	localparam logic [3:0]  CMD_MODE      = 4'h2;
	localparam logic [3:0]  CMD_SPARK     = 4'h3;
	localparam logic [3:0]  CMD_DAC       = 4'h4;
	// Output command fields: injectors in bits 3..0, gate drivers in bits 7..4.
	localparam int          OUT_INJ_LO    = 0;
	localparam int          OUT_GATE_LO   = 4;
	// Mode select fields.
	localparam int          MODE_PWM_LO   = 0;
	localparam int          MODE_RETRY    = 6;
	localparam int          MODE_TEN      = 7;
	localparam int          MODE_GP_LO    = 8;
	// Spark command fields.
	localparam int          SPK_END_LO    = 0;
	localparam int          SPK_OSEC_LO   = 2;
	localparam int          SPK_CLAMP     = 4;
	localparam int          SPK_SOFT      = 5;
	localparam int          SPK_OVERLAP   = 6;
	localparam int          SPK_DWELL_LO  = 7;
	// Threshold command fields.
	localparam int          DAC_MAX_LO    = 0;
	localparam int          DAC_NOM_LO    = 4;
	localparam int          DAC_OPEN_LO   = 8;
	// Reset values.
	localparam logic [1:0]  END_SPARK_RST = 2'b01;   // Supply plus 5.5 V.
	localparam logic [1:0]  OPEN_SEC_RST  = 2'b11;   // 100 us.
	localparam logic [1:0]  DWELL_RST     = 2'b11;   // 32 ms.
	localparam logic [3:0]  MAX_CUR_RST   = 4'h7;    // 14 A.
	localparam logic [3:0]  NOM_CUR_RST   = 4'h3;    // 5.5 A.
	localparam logic [3:0]  OPEN_LD_RST   = 4'hf;    // Off-state open-load checks on.
	localparam logic [7:0]  SPI_CNT_SAT   = 8'hff;
	// Supply states.
	typedef enum logic [1:0] {
		DOM_SLEEP  = 2'b00,
		DOM_POR    = 2'b01,
		DOM_NORMAL = 2'b10
	} dom_state_t;
endpackage

/* File: src/dom_core.sv */
// Output control, mode selection and serial command port of the eight-channel driver.
`timescale 1ns/1ps

// Behaviour
// R01 - Each parallel pin ORs with its serial command bit to form the on command.
// R02 - A high output-disable input holds every output off.
// R03 - Serial port keeps taking commands and returning status while outputs are disabled.
// R04 - Releasing output-disable lets outputs follow current commands and pins.
// R05 - Logic supply loss means sleep, outputs off; its return gives power-on reset.
// R06 - Reset: outputs off, ignition mode, PWM off, open-load detection on.
// R07 - Reset: max current 14 A, nominal 5.5 A, spark level supply plus 5.5 V.
// R08 - Reset: open secondary timer 100 us, dwell timer 32 ms.
// R09 - Reset: soft shutdown, low-voltage clamp and overlap offset disabled.
// R10 - In normal state each gate driver mode is set separately by mode select.
// R11 - Mode bits 8..11 select gate drivers 0..3; 1 is general purpose.
// R12 - General-purpose drivers lose ignition features but keep max-current shutdown.
// R13 - Ten-cylinder bit turns both current flag pins into inputs.
// R14 - Ten-cylinder: max pin stops drivers 0 and 2, nominal pin 1 and 3.
// R15 - Battery over or undervoltage turns every output off.
// R16 - Retry bit 1: outputs stay off after recovery until command re-asserted.
// R17 - Retry bit 0: outputs resume from current pin, serial bit and disable.
// R18 - Ignition-mode gates follow only their pin; general-purpose gates use both.
// R19 - Logic supply undervoltage switches outputs off and resets all control registers.
// R20 - Mode bits 0..3 enable PWM of gates 0..3, only in general purpose.
// R21 - A driver's PWM starts or stops as its enable bit is set or cleared.
// R22 - A command applies on chip select rise after 16 bits or more multiples of eight; the saturating counter refuses frames of 256 bits or more.
// R23 - Sample input on clock rise, shift output on fall, MSB first.
module dom_core (
	input  wire logic                  core_clk,
	input  wire logic                  reset_n,
	input  wire logic                  logic_supply_ok,
	input  wire logic                  battery_overvoltage,
	input  wire logic                  battery_undervoltage,
	input  wire logic                  output_disable_n,
	input  wire logic [3:0]            injector_command_pins,
	input  wire logic [3:0]            gate_command_pins,
	input  wire logic [3:0]            pwm_wave,
	input  wire logic                  max_current_cmp,
	input  wire logic                  nominal_current_cmp,
	input  wire logic                  max_current_flag_in,
	output logic                       max_current_flag_out,
	output logic                       max_current_flag_oe,
	input  wire logic                  nominal_current_flag_in,
	output logic                       nominal_current_flag_out,
	output logic                       nominal_current_flag_oe,
	input  wire logic                  spi_sclk,
	input  wire logic                  spi_cs_n,
	input  wire logic                  spi_si,
	output logic                       spi_so,
	output logic                       spi_so_oe,
	output logic [3:0]                 injector_outputs,
	output logic [3:0]                 gate_driver_outputs,
	output logic [3:0]                 general_purpose_gate_mode,
	output logic                       ten_cylinder_mode,
	output logic [3:0]                 pwm_enable,
	output logic [3:0]                 ignition_feature_enable,
	output logic [1:0]                 end_spark_level,
	output logic [1:0]                 open_secondary_time,
	output logic [1:0]                 dwell_time,
	output logic                       soft_shutdown_enable,
	output logic                       low_voltage_clamp_enable,
	output logic                       overlap_offset_enable,
	output logic [3:0]                 max_current_level,
	output logic [3:0]                 nominal_current_level,
	output logic [3:0]                 open_load_enable,
	output dom_pkg::dom_state_t        supply_state
);
	import dom_pkg::*;

	localparam int SYNC_W = 20;
	localparam logic [SYNC_W-1:0] SYNC_RST = 20'h00004; // Chip select idles high, so no false select after reset.

	// Two-stage synchronisers for every pin but reset_n and pwm_wave; only stage two is read by logic.
	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	logic [SYNC_W-1:0] raw_pins;

	assign raw_pins = {logic_supply_ok, battery_overvoltage, battery_undervoltage, output_disable_n,
		injector_command_pins, gate_command_pins, max_current_cmp, nominal_current_cmp,
		max_current_flag_in, nominal_current_flag_in, spi_sclk, spi_cs_n, spi_si, 1'b0};

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_a <= SYNC_RST;
			sync_b <= SYNC_RST;
		end else begin
			sync_a <= raw_pins;
			sync_b <= sync_a;
		end
	end

	logic       s_supply;
	logic       s_ov;
	logic       s_uv;
	logic       s_disable;
	logic [3:0] s_inj_pin;
	logic [3:0] s_gate_pin;
	logic       s_max_cmp;
	logic       s_nom_cmp;
	logic       s_max_in;
	logic       s_nom_in;
	logic       s_sclk;
	logic       s_cs_n;
	logic       s_si;
	logic       unused_bit;

	assign {s_supply, s_ov, s_uv, s_disable, s_inj_pin, s_gate_pin, s_max_cmp, s_nom_cmp,
		s_max_in, s_nom_in, s_sclk, s_cs_n, s_si, unused_bit} = sync_b;

	// Supply state: sleep while the logic supply is missing, one POR cycle on its return.
	dom_state_t state;
	dom_state_t next_state;

	always_comb begin
		next_state = state;
		unique case (state)
			DOM_SLEEP:  next_state = s_supply ? DOM_POR : DOM_SLEEP; // R05
			DOM_POR:    next_state = s_supply ? DOM_NORMAL : DOM_SLEEP;
			DOM_NORMAL: next_state = s_supply ? DOM_NORMAL : DOM_SLEEP; // R05
			default:    next_state = DOM_SLEEP;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= DOM_SLEEP;
		end else begin
			state <= next_state;
		end
	end

	// Control registers are cleared by reset and held cleared outside normal state.
	logic regs_clear;
	assign regs_clear = (state != DOM_NORMAL); // R19

	// Serial port: edges are found from stage two and a delayed copy of it.
	logic       sclk_d;
	logic       cs_d;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_fall;
	logic       cs_rise;
	logic [CMD_W-1:0] rx_shift;
	logic [CMD_W-1:0] tx_shift;
	logic [7:0] bit_cnt;
	logic [CMD_W-1:0] next_rx_shift;
	logic [CMD_W-1:0] next_tx_shift;
	logic [7:0] next_bit_cnt;
	logic       next_so;
	logic       next_so_oe;
	logic       cmd_valid;
	logic [CMD_W-1:0] status_word;

	assign sclk_rise = s_sclk & ~sclk_d;
	assign sclk_fall = ~s_sclk & sclk_d;
	assign cs_fall   = ~s_cs_n & cs_d;
	assign cs_rise   = s_cs_n & ~cs_d;
	// Only whole words of 16 to 248 bits in steps of eight count.
	assign cmd_valid = cs_rise && (bit_cnt >= 8'(CMD_W)) && (bit_cnt[2:0] == 3'h0) && (bit_cnt != SPI_CNT_SAT); // R22

	// Shift logic runs regardless of the disable pin, so status stays readable.
	always_comb begin
		next_rx_shift = rx_shift;
		next_tx_shift = tx_shift;
		next_bit_cnt  = bit_cnt;
		next_so       = spi_so;
		next_so_oe    = ~s_cs_n; // R03
		if (cs_fall) begin
			next_tx_shift = status_word;
			next_bit_cnt  = 8'h00;
			next_so       = status_word[CMD_W-1]; // R23
		end else if (!s_cs_n) begin
			if (sclk_rise) begin
				next_rx_shift = {rx_shift[CMD_W-2:0], s_si}; // R23
				if (bit_cnt != SPI_CNT_SAT) begin
					next_bit_cnt = bit_cnt + 8'h01;
				end
			end
			if (sclk_fall) begin
				next_tx_shift = {tx_shift[CMD_W-2:0], 1'b0}; // R23
				next_so       = tx_shift[CMD_W-2];
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_d   <= 1'b0;
			cs_d     <= 1'b1;
			rx_shift <= '0;
			tx_shift <= '0;
			bit_cnt  <= 8'h00;
			spi_so   <= 1'b0;
			spi_so_oe <= 1'b0;
		end else begin
			sclk_d   <= s_sclk;
			cs_d     <= s_cs_n;
			rx_shift <= next_rx_shift;
			tx_shift <= next_tx_shift;
			bit_cnt  <= next_bit_cnt;
			spi_so   <= next_so;
			spi_so_oe <= next_so_oe;
		end
	end

	// Command registers, loaded only when a valid word ends in normal state.
	logic [7:0] serial_on;
	logic       retry_hold_mode;
	logic [7:0] next_serial_on;
	logic [3:0] next_gp_mode;
	logic [3:0] next_pwm_en;
	logic       next_ten;
	logic       next_retry;
	logic [1:0] next_end_spark;
	logic [1:0] next_open_sec;
	logic [1:0] next_dwell;
	logic       next_soft;
	logic       next_clamp;
	logic       next_overlap;
	logic [3:0] next_max_lvl;
	logic [3:0] next_nom_lvl;
	logic [3:0] next_open_ld;
	logic [3:0] pwm_en;
	logic [3:0] cmd_code;

	assign cmd_code = rx_shift[CMD_CODE_HI:CMD_CODE_LO];

	always_comb begin
		next_serial_on = serial_on;
		next_gp_mode   = general_purpose_gate_mode;
		next_pwm_en    = pwm_en;
		next_ten       = ten_cylinder_mode;
		next_retry     = retry_hold_mode;
		next_end_spark = end_spark_level;
		next_open_sec  = open_secondary_time;
		next_dwell     = dwell_time;
		next_soft      = soft_shutdown_enable;
		next_clamp     = low_voltage_clamp_enable;
		next_overlap   = overlap_offset_enable;
		next_max_lvl   = max_current_level;
		next_nom_lvl   = nominal_current_level;
		next_open_ld   = open_load_enable;
		if (regs_clear) begin
			// Same values as the asynchronous reset below.
			next_serial_on = 8'h00; // R06 R19
			next_gp_mode   = 4'h0; // R06
			next_pwm_en    = 4'h0; // R06
			next_ten       = 1'b0;
			next_retry     = 1'b0; // R17
			next_end_spark = END_SPARK_RST; // R07
			next_open_sec  = OPEN_SEC_RST; // R08
			next_dwell     = DWELL_RST; // R08
			next_soft      = 1'b0; // R09
			next_clamp     = 1'b0; // R09
			next_overlap   = 1'b0; // R09
			next_max_lvl   = MAX_CUR_RST; // R07
			next_nom_lvl   = NOM_CUR_RST; // R07
			next_open_ld   = OPEN_LD_RST; // R06
		end else if (cmd_valid) begin // R22
			unique case (cmd_code)
				CMD_OUTPUT: begin
					next_serial_on = rx_shift[7:0];
				end
				CMD_MODE: begin
					next_gp_mode = rx_shift[MODE_GP_LO +: 4]; // R10 R11
					next_pwm_en  = rx_shift[MODE_PWM_LO +: 4]; // R20 R21
					next_ten     = rx_shift[MODE_TEN]; // R13
					next_retry   = rx_shift[MODE_RETRY]; // R16
				end
				CMD_SPARK: begin
					next_end_spark = rx_shift[SPK_END_LO +: 2];
					next_open_sec  = rx_shift[SPK_OSEC_LO +: 2];
					next_dwell     = rx_shift[SPK_DWELL_LO +: 2];
					next_clamp     = rx_shift[SPK_CLAMP];
					next_soft      = rx_shift[SPK_SOFT];
					next_overlap   = rx_shift[SPK_OVERLAP];
				end
				CMD_DAC: begin
					next_max_lvl = rx_shift[DAC_MAX_LO +: 4];
					next_nom_lvl = rx_shift[DAC_NOM_LO +: 4];
					next_open_ld = rx_shift[DAC_OPEN_LO +: 4];
				end
				default: begin
					// Unknown command codes are ignored.
					next_serial_on = serial_on;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			serial_on                 <= 8'h00;
			general_purpose_gate_mode <= 4'h0;
			pwm_en                    <= 4'h0;
			ten_cylinder_mode         <= 1'b0;
			retry_hold_mode           <= 1'b0;
			end_spark_level           <= END_SPARK_RST;
			open_secondary_time       <= OPEN_SEC_RST;
			dwell_time                <= DWELL_RST;
			soft_shutdown_enable      <= 1'b0;
			low_voltage_clamp_enable  <= 1'b0;
			overlap_offset_enable     <= 1'b0;
			max_current_level         <= MAX_CUR_RST;
			nominal_current_level     <= NOM_CUR_RST;
			open_load_enable          <= OPEN_LD_RST;
		end else begin
			serial_on                 <= next_serial_on;
			general_purpose_gate_mode <= next_gp_mode;
			pwm_en                    <= next_pwm_en;
			ten_cylinder_mode         <= next_ten;
			retry_hold_mode           <= next_retry;
			end_spark_level           <= next_end_spark;
			open_secondary_time       <= next_open_sec;
			dwell_time                <= next_dwell;
			soft_shutdown_enable      <= next_soft;
			low_voltage_clamp_enable  <= next_clamp;
			overlap_offset_enable     <= next_overlap;
			max_current_level         <= next_max_lvl;
			nominal_current_level     <= next_nom_lvl;
			open_load_enable          <= next_open_ld;
		end
	end

	// Configuration seen by the ignition and PWM logic outside this block.
	assign pwm_enable              = pwm_en & general_purpose_gate_mode; // R20 R21
	assign ignition_feature_enable = ~general_purpose_gate_mode; // R12

	// Per-output requests; index 3..0 injectors, 7..4 gate drivers.
	logic [7:0] request;
	logic [3:0] gate_req;
	logic [3:0] trip_src;
	logic [3:0] trip_latch;
	logic [7:0] volt_hold;
	logic [3:0] next_trip_latch;
	logic [7:0] next_volt_hold;
	logic [7:0] next_outputs;
	logic       volt_fault;

	assign volt_fault = s_ov | s_uv;

	// Ignition-mode gates ignore the serial bit; general-purpose gates add it and the PWM wave.
	always_comb begin
		for (int g = 0; g < 4; g++) begin
			gate_req[g] = s_gate_pin[g] | (general_purpose_gate_mode[g] &
				(serial_on[OUT_GATE_LO+g] | (pwm_enable[g] & pwm_wave[g]))); // R18 R01 R21
			// Both modes keep the current shutdown; ten-cylinder takes it from the flag pins.
			if (ten_cylinder_mode) begin
				trip_src[g] = g[0] ? s_nom_in : s_max_in; // R14
			end else begin
				trip_src[g] = s_max_cmp; // R12
			end
		end
	end

	assign request = {gate_req, s_inj_pin | serial_on[OUT_INJ_LO +: 4]}; // R01

	// Latches hold an output off until its command is dropped; a new trip beats the release.
	always_comb begin
		next_trip_latch = trip_latch;
		next_volt_hold  = volt_hold;
		for (int g = 0; g < 4; g++) begin
			if (trip_src[g] && gate_req[g]) begin
				next_trip_latch[g] = 1'b1; // R14
			end else if (!gate_req[g]) begin
				next_trip_latch[g] = 1'b0;
			end
		end
		for (int i = 0; i < 8; i++) begin
			if (volt_fault && retry_hold_mode) begin
				next_volt_hold[i] = 1'b1; // R16
			end else if (!request[i]) begin
				next_volt_hold[i] = 1'b0; // R16
			end
		end
		if (regs_clear) begin
			next_trip_latch = 4'h0;
			next_volt_hold  = 8'h00;
		end
		// Disable pin high means outputs off; registers above keep their contents.
		if (regs_clear || s_disable || volt_fault) begin // R02 R05 R15
			next_outputs = 8'h00;
		end else begin
			next_outputs = request & ~volt_hold & ~{next_trip_latch, 4'h0}; // R04 R17 R14
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			trip_latch          <= 4'h0;
			volt_hold           <= 8'h00;
			injector_outputs    <= 4'h0;
			gate_driver_outputs <= 4'h0;
		end else begin
			trip_latch          <= next_trip_latch;
			volt_hold           <= next_volt_hold;
			injector_outputs    <= next_outputs[3:0];
			gate_driver_outputs <= next_outputs[7:4];
		end
	end

	// Flag pins stop driving in ten-cylinder mode and become shutdown inputs.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			max_current_flag_out     <= 1'b0;
			nominal_current_flag_out <= 1'b0;
			max_current_flag_oe      <= 1'b0;
			nominal_current_flag_oe  <= 1'b0;
		end else begin
			max_current_flag_out     <= s_max_cmp;
			nominal_current_flag_out <= s_nom_cmp;
			max_current_flag_oe      <= ~ten_cylinder_mode & ~regs_clear; // R13
			nominal_current_flag_oe  <= ~ten_cylinder_mode & ~regs_clear; // R13
		end
	end

	assign status_word  = {trip_latch, volt_hold, volt_fault, ten_cylinder_mode, state};
	assign supply_state = state;
endmodule

/* File: verif/dom_core_properties.sv */
// Concurrent checks on the output control and mode ports of the driver block.
`timescale 1ns/1ps
module dom_core_properties (
	input wire logic                core_clk,
	input wire logic                reset_n,
	input wire logic                output_disable_n,
	input wire logic                battery_overvoltage,
	input wire logic                battery_undervoltage,
	input wire logic [3:0]          gate_command_pins,
	input wire logic                max_current_flag_in,
	input wire logic                max_current_flag_oe,
	input wire logic                nominal_current_flag_oe,
	input wire logic                spi_cs_n,
	input wire logic                spi_so_oe,
	input wire logic [3:0]          injector_outputs,
	input wire logic [3:0]          gate_driver_outputs,
	input wire logic [3:0]          general_purpose_gate_mode,
	input wire logic                ten_cylinder_mode,
	input wire logic [3:0]          pwm_enable,
	input wire logic [3:0]          ignition_feature_enable,
	input wire dom_pkg::dom_state_t supply_state
);
	import dom_pkg::*;
	logic all_off;

	// Repetition counts leave room for the two-flop input synchronisers.
	assign all_off = (injector_outputs == 4'h0) && (gate_driver_outputs == 4'h0);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	a_disable_all_off: assert property (output_disable_n [*4] |=> all_off)
		else $error("output on while disabled");
	a_sleep_all_off: assert property (supply_state != DOM_NORMAL |=> all_off)
		else $error("output on outside normal state");
	a_battery_all_off: assert property ((battery_overvoltage || battery_undervoltage) [*4] |=> all_off)
		else $error("output on during battery fault");
	a_ignition_follows_mode: assert property (ignition_feature_enable == ~general_purpose_gate_mode)
		else $error("ignition features wrong for mode");
	a_pwm_gp_only: assert property ((pwm_enable & ~general_purpose_gate_mode) == 4'h0)
		else $error("pwm enabled on ignition gate");
	a_ten_flags_input: assert property (ten_cylinder_mode [*2] |-> !max_current_flag_oe && !nominal_current_flag_oe)
		else $error("flag pin driven in ten-cylinder mode");
	a_ten_max_trip: assert property ((ten_cylinder_mode && max_current_flag_in) [*6] |-> (gate_driver_outputs & 4'h5) == 4'h0)
		else $error("gates 0 or 2 on despite max input");
	a_ignition_pin_only: assert property ((gate_driver_outputs & ~general_purpose_gate_mode & ~$past(general_purpose_gate_mode)
		& ~($past(gate_command_pins, 2) | $past(gate_command_pins, 3))) == 4'h0)
		else $error("ignition gate on without its pin");
	a_so_enable_low: assert property (!spi_cs_n [*4] |-> spi_so_oe)
		else $error("serial output not driven while selected");
	a_so_release_high: assert property (spi_cs_n [*4] |-> !spi_so_oe)
		else $error("serial output driven while deselected");
endmodule

bind dom_core dom_core_properties u_dom_core_properties (.core_clk, .reset_n, .output_disable_n, .battery_overvoltage,
	.battery_undervoltage, .gate_command_pins, .max_current_flag_in, .max_current_flag_oe, .nominal_current_flag_oe,
	.spi_cs_n, .spi_so_oe, .injector_outputs, .gate_driver_outputs, .general_purpose_gate_mode, .ten_cylinder_mode,
	.pwm_enable, .ignition_feature_enable, .supply_state);

/* File: verif/dom_mcu.sv */
// Controller model that drives the serial command link and collects status.
`timescale 1ns/1ps
module dom_mcu (
	output logic       spi_sclk,
	output logic       spi_cs_n,
	output logic       spi_si,
	input  wire logic  spi_so
);
	logic [15:0] status;

	// The link clock stands still and deselected between frames.
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end

	// Sends nbits MSB first; leading bits beyond sixteen are zero padding.
	task automatic xfer(input logic [15:0] word, input int nbits, input int half);
		logic [31:0] v;
		v = {16'h0000, word};
		#37;
		spi_cs_n = 1'b0;
		#(half);
		for (int i = nbits - 1; i >= 0; i--) begin
			spi_si = v[i];
			#(half);
			spi_sclk = 1'b1;
			status = {status[14:0], spi_so};
			#(half);
			spi_sclk = 1'b0;
		end
		// Invert the data line so a stale bit cannot pass for a held one.
		spi_si = ~spi_si;
		#(half);
		spi_cs_n = 1'b1;
		#(half);
	endtask
endmodule

/* File: verif/test_dom_core.sv */
// Self-checking bench for the output control and mode block.
`timescale 1ns/1ps
module test_dom_core;
	import dom_pkg::*;
	logic        core_clk, reset_n, logic_supply_ok, battery_overvoltage, battery_undervoltage, output_disable_n;
	logic [3:0]  injector_command_pins, gate_command_pins, pwm_wave;
	logic        max_drv, nom_drv, max_current_flag_in, nominal_current_flag_in, spi_so_oe, so_line;
	logic        max_current_flag_out, max_current_flag_oe, nominal_current_flag_out, nominal_current_flag_oe;
	logic        spi_sclk, spi_cs_n, spi_si, spi_so, ten_cylinder_mode, look;
	logic [3:0]  injector_outputs, gate_driver_outputs, general_purpose_gate_mode, pwm_enable;
	logic [3:0]  ignition_feature_enable, max_current_level, nominal_current_level, open_load_enable;
	logic [1:0]  end_spark_level, open_secondary_time, dwell_time;
	logic        soft_shutdown_enable, low_voltage_clamp_enable, overlap_offset_enable;
	dom_state_t  supply_state;
	logic [31:0] seed;
	logic [18:0] note, notes[$];
	int          failures, n_tests;
	int          cycles = 0;

	// Flag pins resolve from the block's enable; the released serial line toggles.
	assign max_current_flag_in = max_current_flag_oe ? max_current_flag_out : max_drv;
	assign nominal_current_flag_in = nominal_current_flag_oe ? nominal_current_flag_out : nom_drv;
	assign so_line = spi_so_oe ? spi_so : ~core_clk;

	dom_core u_dom_core (.core_clk, .reset_n, .logic_supply_ok, .battery_overvoltage, .battery_undervoltage,
		.output_disable_n, .injector_command_pins, .gate_command_pins, .pwm_wave, .max_current_cmp(max_drv),
		.nominal_current_cmp(nom_drv), .max_current_flag_in, .max_current_flag_out, .max_current_flag_oe,
		.nominal_current_flag_in, .nominal_current_flag_out, .nominal_current_flag_oe, .spi_sclk, .spi_cs_n,
		.spi_si, .spi_so, .spi_so_oe, .injector_outputs, .gate_driver_outputs, .general_purpose_gate_mode,
		.ten_cylinder_mode, .pwm_enable, .ignition_feature_enable, .end_spark_level, .open_secondary_time,
		.dwell_time, .soft_shutdown_enable, .low_voltage_clamp_enable, .overlap_offset_enable,
		.max_current_level, .nominal_current_level, .open_load_enable, .supply_state);
	dom_mcu u_dom_mcu (.spi_sclk, .spi_cs_n, .spi_si, .spi_so(so_line));

	// Free-running core clock.
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [15:0] obs(input logic [2:0] s);
		case (s)
			3'd0: return {8'h00, gate_driver_outputs, injector_outputs};
			3'd1: return {general_purpose_gate_mode, pwm_enable, ignition_feature_enable, 3'h0, ten_cylinder_mode};
			3'd2: return {2'b00, end_spark_level, open_secondary_time, dwell_time, soft_shutdown_enable,
				low_voltage_clamp_enable, overlap_offset_enable, 1'b0, open_load_enable};
			3'd3: return {max_current_level, nominal_current_level, 8'h00};
			default: return {13'h0000, u_dom_mcu.status[2:0]};
		endcase
	endfunction

	// Waits out the input synchronisers, then notes one expectation for the monitor.
	task automatic want(input logic [2:0] s, input logic [15:0] v);
		repeat (8) @(negedge core_clk);
		notes.push_back({s, v});
		look <= 1'b1;
		@(negedge core_clk);
		look <= 1'b0;
	endtask

	task automatic cmd(input logic [15:0] w);
		u_dom_mcu.xfer(w, 16, 400);
		@(negedge core_clk);
	endtask

	task automatic wait_normal();
		for (int i = 0; i < 20 && supply_state !== DOM_NORMAL; i++)
			@(negedge core_clk);
	endtask

	task automatic end_of_test();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Monitor: each flagged cycle takes the oldest note and compares it.
	always @(negedge core_clk) begin
		if (look === 1'b1) begin
			note = notes.pop_front();
			n_tests++;
			if (obs(note[18:16]) !== note[15:0]) begin
				failures++;
				$display("BAD t=%0t sel %0d got %h want %h", $time, note[18:16], obs(note[18:16]), note[15:0]);
			end
		end
	end

	// Hang guard, well above the expected 3300 cycles.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			$display("BAD t=%0t timeout", $time);
			end_of_test();
		end
	end

	initial begin
		{reset_n, battery_overvoltage, battery_undervoltage, output_disable_n, max_drv, nom_drv, look} = 7'h00;
		{injector_command_pins, gate_command_pins, pwm_wave} = 12'h000;
		logic_supply_ok = 1'b1;
		seed = 32'h877e;
		failures = 0;
		n_tests = 0;
		repeat (2) @(negedge core_clk);
		reset_n = 1'b1;
		wait_normal();
		want(3'd0, 16'h0000);
		want(3'd1, 16'h00f0);
		want(3'd2, {2'b00, END_SPARK_RST, OPEN_SEC_RST, DWELL_RST, 4'h0, OPEN_LD_RST});
		want(3'd3, {MAX_CUR_RST, NOM_CUR_RST, 8'h00});
		// Random pins and serial bits, first with ignition gates, then general-purpose.
		for (int m = 0; m < 2; m++) begin
			cmd({CMD_MODE, (m ? 4'hf : 4'h0), 8'h00});
			for (int k = 0; k < 4; k++) begin
				seed = lfsr(seed);
				@(negedge core_clk);
				{gate_command_pins, injector_command_pins} = seed[7:0];
				cmd({CMD_OUTPUT, 4'h0, seed[15:8]});
				want(3'd0, {8'h00, seed[7:4] | (m ? seed[15:12] : 4'h0), seed[3:0] | seed[11:8]});
			end
		end
		// Disable holds outputs off while the serial port keeps working.
		@(negedge core_clk);
		output_disable_n = 1'b1;
		{gate_command_pins, injector_command_pins} = 8'hff;
		want(3'd0, 16'h0000);
		cmd({CMD_OUTPUT, 12'h000});
		want(3'd4, 16'h0002);
		@(negedge core_clk);
		output_disable_n = 1'b0;
		want(3'd0, 16'h00ff);
		// PWM only on general-purpose gates, started and stopped by its bits.
		cmd({CMD_MODE, 4'b0101, 8'h0f});
		want(3'd1, 16'h55a0);
		@(negedge core_clk);
		{gate_command_pins, injector_command_pins} = 8'h00;
		pwm_wave = 4'b0001;
		want(3'd0, 16'h0010);
		cmd({CMD_MODE, 4'b0101, 8'h00});
		want(3'd0, 16'h0000);
		// Ten-cylinder mode: flag pins become shutdown inputs.
		cmd({CMD_MODE, 12'h080});
		want(3'd1, 16'h00f1);
		@(negedge core_clk);
		gate_command_pins = 4'hf;
		max_drv = 1'b1;
		want(3'd0, 16'h00a0);
		@(negedge core_clk);
		{max_drv, nom_drv, gate_command_pins} = 6'h10;
		repeat (4) @(negedge core_clk);
		gate_command_pins = 4'hf;
		want(3'd0, 16'h0050);
		@(negedge core_clk);
		{nom_drv, gate_command_pins} = 5'h00;
		// Battery fault with both recovery policies.
		for (int r = 0; r < 2; r++) begin
			cmd({CMD_MODE, 4'h0, (r ? 8'h40 : 8'h00)});
			{gate_command_pins, injector_command_pins} = 8'hff;
			want(3'd0, 16'h00ff);
			{battery_undervoltage, battery_overvoltage} = r ? 2'b10 : 2'b01;
			want(3'd0, 16'h0000);
			{battery_undervoltage, battery_overvoltage} = 2'b00;
			want(3'd0, r ? 16'h0000 : 16'h00ff);
			{gate_command_pins, injector_command_pins} = 8'h00;
			repeat (4) @(negedge core_clk);
			{gate_command_pins, injector_command_pins} = 8'hff;
			want(3'd0, 16'h00ff);
		end
		// Logic supply loss: sleep, registers back to reset values.
		cmd({CMD_MODE, 4'hf, 8'h01});
		logic_supply_ok = 1'b0;
		want(3'd0, 16'h0000);
		want(3'd1, 16'h00f0);
		logic_supply_ok = 1'b1;
		wait_normal();
		want(3'd0, 16'h00ff);
		// A 12-bit frame is refused, a longer byte multiple is taken.
		{gate_command_pins, injector_command_pins} = 8'h00;
		u_dom_mcu.xfer({CMD_OUTPUT, 12'h0ff}, 12, 700);
		want(3'd0, 16'h0000);
		u_dom_mcu.xfer({CMD_OUTPUT, 12'h00f}, 24, 700);
		want(3'd0, 16'h000f);
		end_of_test();
	end
endmodule
